// *** design/blcl_pkg.sv ***
// package of constants and types for the current limit, lock and fault block
package blcl_pkg;
   // advance code layout
   localparam int ADV_CODE_W = 7;
   localparam int ADV_MANT_LSB = 0;
   localparam int ADV_MANT_W = 4;
   localparam int ADV_EXP_LSB = 4;
   localparam int ADV_EXP_W = 3;
   // advance result in half-step units of 1.25 us: 2.5 us = 2 units
   localparam int ADV_STEP_UNITS = 2;
   localparam int ADV_TIME_W = 13;
   // number of lock sources (five schemes plus no-motor)
   localparam int LOCK_SRC_N = 6;
   localparam int NO_MOTOR_BIT = 3;
   // arithmetic widths
   localparam int PARAM_W = 7;
   localparam int SPEED_W = 16;
   localparam int VOLT_W = 24;
   // clock and lock-off time
   localparam int CLK_MHZ = 20;
   localparam int LOCK_OFF_MS = 5000;
   localparam int LOCK_OFF_CYC = LOCK_OFF_MS * 1000 * CLK_MHZ;
   localparam int CNT_W = 32;
   // anti-surge hold time
   localparam int SURGE_US = 10;
   localparam int SURGE_CYC = SURGE_US * CLK_MHZ;
   // register map (byte addresses)
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_PARAM = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
   localparam logic [7:0] ADDR_ADV = 8'h14;
   localparam logic [7:0] ADDR_ULIMIT = 8'h18;
   // control register fields
   localparam int CTRL_ADV_LSB = 0;
   localparam int CTRL_MODE_BIT = 7;
   localparam int CTRL_THR_LSB = 8;
   localparam int CTRL_THR_W = 4;
   localparam int CTRL_EN_LSB = 12;
   localparam logic [31:0] CTRL_RESET = 32'h0003_F000;
   localparam int PARAM_RES_LSB = 0;
   localparam int PARAM_KT_LSB = 8;
   localparam logic [31:0] PARAM_RESET = 32'h0000_0000;
   // interrupt events
   localparam int IRQ_N = 4;
   localparam int IRQ_LOCK = 0;
   localparam int IRQ_OCP = 1;
   localparam int IRQ_RETRY = 2;
   localparam int IRQ_ACCEL = 3;
   // htrans encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ = 2'h3;

   typedef enum logic [1:0] {ST_RUN, ST_SURGE, ST_LOCKOFF} blcl_state_type;

   // computes advance setting in 1.25 us units
   function automatic logic [ADV_TIME_W-1:0] blcl_adv_units(input logic [ADV_CODE_W-1:0] c);
      logic [ADV_TIME_W-1:0] m;
      m = ADV_TIME_W'(c[ADV_MANT_LSB +: ADV_MANT_W]) * ADV_TIME_W'(ADV_STEP_UNITS);
      return m << c[ADV_EXP_LSB +: ADV_EXP_W];
   endfunction
endpackage

// *** design/blcl_lim_if.sv ***
// interface carrying the current limit computation between modules
`timescale 1ns/10ps
interface blcl_lim_if;
   logic [3:0] threshold;
   logic [6:0] resistance;
   logic [6:0] kt;
   logic [15:0] speed;
   logic [23:0] ulimit;
   modport ctrl (output threshold, resistance, kt, speed, input ulimit);
   modport calc (input threshold, resistance, kt, speed, output ulimit);
endinterface

// *** design/blcl_ulimit.sv ***
// acceleration voltage limit calculator
`timescale 1ns/10ps
module blcl_ulimit (
   input wire logic clk,
   input wire logic reset,
   blcl_lim_if.calc lim
);
   import blcl_pkg::*;
   typedef struct packed {
      logic [VOLT_W-1:0] ulimit;
   } blcl_ul_type;
   blcl_ul_type st_ff;
   blcl_ul_type nxt_st;

   // limit = current times resistance plus speed times kt, no current sensing
   always_comb begin
      nxt_st = st_ff;
      nxt_st.ulimit = VOLT_W'(lim.threshold) * VOLT_W'(lim.resistance)
         + VOLT_W'(lim.speed) * VOLT_W'(lim.kt);
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign lim.ulimit = st_ff.ulimit;
endmodule // blcl_ulimit

// *** design/blcl_top.sv ***
// current limit, lock detect and fault handling with AHB-Lite registers
// Functional notes
// - advance code: upper three bits shift lower four bits, step 2.5 us
// - advance time equals 2.5 us times mantissa shifted by exponent
// - mode 0 fixed advance; mode 1 scaled by (amplitude minus bemf)/amplitude
// - three limits: acceleration, lock-detect, overcurrent
// - acceleration limit only caps amplitude, no fault, closed loop only
// - cap equals threshold current times resistance plus speed times kt
// - lock-detect limit trip stops drive, enters lock state, mechanical error
// - overcurrent stops drive until it clears; fixed, never disabled
// - six lock sources each disabled by one enable bit
// - motor locked flag set on any enabled lock condition
// - per-source fault code set even if disabled, reloaded from the lock inputs on restart
// - lock or no-motor puts outputs high impedance with anti-surge
// - after lock-off interval the motor restart is attempted
`timescale 1ns/10ps
module blcl_top
   import blcl_pkg::*;
#(
   parameter int LOCK_OFF_CYCLES = LOCK_OFF_CYC
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [blcl_pkg::LOCK_SRC_N-1:0] lock_detect,
   input wire logic overcurrent_protect,
   input wire logic closed_loop,
   input wire logic [blcl_pkg::SPEED_W-1:0] motor_speed,
   input wire logic [blcl_pkg::VOLT_W-1:0] phase_amplitude,
   input wire logic [blcl_pkg::VOLT_W-1:0] bemf_amplitude,
   input wire logic [blcl_pkg::VOLT_W-1:0] speed_command,
   output logic [blcl_pkg::VOLT_W-1:0] amplitude_out,
   output logic [blcl_pkg::ADV_TIME_W-1:0] advance_units,
   output logic drive_enable,
   output logic anti_surge,
   output logic restart_pulse,
   output logic irq
);
   import blcl_pkg::*;

   // ************************************************************
   // state record
   // ************************************************************
   typedef struct packed {
      logic [31:0] ctrl;
      logic [31:0] param;
      logic [IRQ_N-1:0] irq_stat;
      logic [IRQ_N-1:0] irq_mask;
      logic [LOCK_SRC_N-1:0] fault_source_code;
      logic motor_locked_flag;
      blcl_state_type state;
      logic [CNT_W-1:0] count;
      logic ocp_prev;
      logic restart;
      logic drive;
      logic surge;
      logic [VOLT_W-1:0] amp;
      logic [ADV_TIME_W-1:0] adv;
      logic wr_pend;
      logic rd_pend;
      logic [7:0] addr;
      logic [31:0] rdata;
   } blcl_top_type;

   blcl_top_type st_ff;
   blcl_top_type nxt_st;
   blcl_lim_if lim ();

   logic [ADV_CODE_W-1:0] advance_time_code;
   logic advance_mode_select;
   logic [CTRL_THR_W-1:0] accel_current_threshold;
   logic [LOCK_SRC_N-1:0] lock_scheme_enables;
   logic [LOCK_SRC_N-1:0] lock_hit;
   logic any_lock;
   logic [IRQ_N-1:0] irq_event;
   logic accel_active;
   logic [ADV_TIME_W-1:0] adv_fixed;
   logic [VOLT_W+ADV_TIME_W-1:0] adv_prod;
   logic [VOLT_W-1:0] amp_minus_bemf;
   logic addr_take;

   // ************************************************************
   // register decode
   // ************************************************************
   // register reached by a bus offset; anything unmapped falls to none
   typedef enum logic [2:0] {SEL_CTRL, SEL_PARAM, SEL_STATUS, SEL_IRQ_STAT, SEL_IRQ_MASK,
      SEL_ADV, SEL_ULIMIT, SEL_NONE} blcl_sel_type;

   // one decoder for both bus paths, so a write and a read of one offset
   // always meet the same register; only the low address byte is decoded,
   // so the map repeats every 256 bytes
   function automatic blcl_sel_type blcl_reg_select(input logic [7:0] a);
      blcl_sel_type s;
      unique case (a)
         ADDR_CTRL: s = SEL_CTRL;
         ADDR_PARAM: s = SEL_PARAM;
         ADDR_STATUS: s = SEL_STATUS;
         ADDR_IRQ_STAT: s = SEL_IRQ_STAT;
         ADDR_IRQ_MASK: s = SEL_IRQ_MASK;
         ADDR_ADV: s = SEL_ADV;
         ADDR_ULIMIT: s = SEL_ULIMIT;
         default: s = SEL_NONE;
      endcase
      return s;
   endfunction

   // ************************************************************
   // field decode
   // ************************************************************
   // fields come from the registered control word, one cycle after a write
   assign advance_time_code = st_ff.ctrl[CTRL_ADV_LSB +: ADV_CODE_W];
   assign advance_mode_select = st_ff.ctrl[CTRL_MODE_BIT];
   assign accel_current_threshold = st_ff.ctrl[CTRL_THR_LSB +: CTRL_THR_W];
   assign lock_scheme_enables = st_ff.ctrl[CTRL_EN_LSB +: LOCK_SRC_N];

   // limit calculator inputs
   // speed is the measured rotor speed, not the command
   assign lim.threshold = accel_current_threshold;
   assign lim.resistance = st_ff.param[PARAM_RES_LSB +: PARAM_W];
   assign lim.kt = st_ff.param[PARAM_KT_LSB +: PARAM_W];
   assign lim.speed = motor_speed;

   // limit registered in its own module: one cycle behind a speed change
   blcl_ulimit u_ulimit (
      .clk(clk),
      .reset(reset),
      .lim(lim)
   );

   // ************************************************************
   // lock sources
   // ************************************************************
   // each source gated by its own enable
   // the no-motor check is one of the six and is gated the same way
   genvar g;
   generate
      for (g = 0; g < LOCK_SRC_N; g++) begin : g_lock
         assign lock_hit[g] = lock_detect[g] & lock_scheme_enables[g];
      end
   endgenerate
   assign any_lock = |lock_hit;

   // ************************************************************
   // limit and advance
   // ************************************************************
   // acceleration limit only meaningful when closed loop
   assign accel_active = closed_loop && (speed_command > lim.ulimit);

   // advance time, mode 1 scales by remaining voltage headroom
   assign adv_fixed = blcl_adv_units(advance_time_code);
   assign amp_minus_bemf = (phase_amplitude > bemf_amplitude) ?
      phase_amplitude - bemf_amplitude : '0;
   assign adv_prod = (VOLT_W+ADV_TIME_W)'(adv_fixed) * (VOLT_W+ADV_TIME_W)'(amp_minus_bemf);

   // address phase accepted; hreadyout is tied high, so no wait state exists
   assign addr_take = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

   // ************************************************************
   // next-state logic
   // ************************************************************
   always_comb begin
      // defaults: pulses drop after one cycle, everything else holds
      nxt_st = st_ff;
      irq_event = '0;
      nxt_st.restart = 1'b0;
      nxt_st.ocp_prev = overcurrent_protect;

      // fault sources latched even when disabled
      // a lock seen during surge or lock-off is still recorded
      nxt_st.fault_source_code = st_ff.fault_source_code | lock_detect;

      unique case (st_ff.state)
         ST_RUN: begin
            if (any_lock) begin
               // lock-detect limit and other schemes stop the drive
               nxt_st.state = ST_SURGE;
               nxt_st.motor_locked_flag = 1'b1;
               nxt_st.count = CNT_W'(SURGE_CYC);
               irq_event[IRQ_LOCK] = 1'b1;
            end
         end
         ST_SURGE: begin
            // energy returned safely before drivers float
            if (st_ff.count <= CNT_W'(1)) begin
               nxt_st.state = ST_LOCKOFF;
               nxt_st.count = CNT_W'(LOCK_OFF_CYCLES);
            end else begin
               nxt_st.count = st_ff.count - CNT_W'(1);
            end
         end
         ST_LOCKOFF: begin
            // drivers stay off for the whole wait; lock inputs only feed the code
            if (st_ff.count <= CNT_W'(1)) begin
               nxt_st.state = ST_RUN;
               nxt_st.restart = 1'b1;
               nxt_st.motor_locked_flag = 1'b0;
               nxt_st.fault_source_code = lock_detect;
               irq_event[IRQ_RETRY] = 1'b1;
            end else begin
               nxt_st.count = st_ff.count - CNT_W'(1);
            end
         end
      endcase

      // overcurrent: fixed, cannot be masked off the drive path
      // it needs no state: the drive returns the cycle after it clears
      nxt_st.drive = (nxt_st.state == ST_RUN) && !overcurrent_protect;
      nxt_st.surge = (nxt_st.state == ST_SURGE);
      irq_event[IRQ_OCP] = overcurrent_protect && !st_ff.ocp_prev;
      irq_event[IRQ_ACCEL] = accel_active && !(st_ff.amp == lim.ulimit);

      // amplitude capped, drive keeps spinning (no fault)
      if (!nxt_st.drive) begin
         nxt_st.amp = '0;
      end else if (accel_active) begin
         nxt_st.amp = lim.ulimit;
      end else begin
         nxt_st.amp = speed_command;
      end

      // the divide is a long combinational path, accepted as the advance moves slowly
      // a zero amplitude leaves the ratio undefined, so the fixed setting is kept
      if (advance_mode_select && phase_amplitude != '0) begin
         nxt_st.adv = ADV_TIME_W'(adv_prod / (VOLT_W+ADV_TIME_W)'(phase_amplitude));
      end else begin
         nxt_st.adv = adv_fixed;
      end

      // bus data phase write; set wins over write-one-clear
      nxt_st.wr_pend = addr_take && hwrite;
      nxt_st.rd_pend = addr_take && !hwrite;
      if (addr_take) begin
         nxt_st.addr = haddr[7:0];
      end
      nxt_st.irq_stat = st_ff.irq_stat;
      // status, advance and limit are read-only: their writes fall to the default
      if (st_ff.wr_pend) begin
         unique case (blcl_reg_select(st_ff.addr))
            SEL_CTRL: nxt_st.ctrl = hwdata;
            SEL_PARAM: nxt_st.param = hwdata;
            SEL_IRQ_STAT: nxt_st.irq_stat = st_ff.irq_stat & ~hwdata[IRQ_N-1:0];
            SEL_IRQ_MASK: nxt_st.irq_mask = hwdata[IRQ_N-1:0];
            default: ;
         endcase
      end
      nxt_st.irq_stat = nxt_st.irq_stat | irq_event;

      // read data registered at address phase
      // a read right behind a write to one register still returns the old value
      nxt_st.rdata = '0;
      if (addr_take && !hwrite) begin
         unique case (blcl_reg_select(haddr[7:0]))
            SEL_CTRL: nxt_st.rdata = st_ff.ctrl;
            SEL_PARAM: nxt_st.rdata = st_ff.param;
            SEL_STATUS: nxt_st.rdata = {16'h0000, 2'h0, st_ff.fault_source_code,
               st_ff.surge, st_ff.drive, st_ff.motor_locked_flag, overcurrent_protect,
               2'h0, st_ff.state};
            SEL_IRQ_STAT: nxt_st.rdata = {28'h0000000, st_ff.irq_stat};
            SEL_IRQ_MASK: nxt_st.rdata = {28'h0000000, st_ff.irq_mask};
            SEL_ADV: nxt_st.rdata = {19'h00000, st_ff.adv};
            SEL_ULIMIT: nxt_st.rdata = {8'h00, lim.ulimit};
            default: nxt_st.rdata = '0;
         endcase
      end
   end

   // ************************************************************
   // state register
   // ************************************************************
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_ff <= '0;
         st_ff.ctrl <= CTRL_RESET;
         st_ff.param <= PARAM_RESET;
         st_ff.state <= ST_RUN;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // outputs
   assign hrdata = st_ff.rdata;
   assign hreadyout = 1'b1; // zero wait states
   assign hresp = 1'b0;
   assign amplitude_out = st_ff.amp;
   assign advance_units = st_ff.adv;
   assign drive_enable = st_ff.drive;
   assign anti_surge = st_ff.surge;
   assign restart_pulse = st_ff.restart;
   // a level: stays high until software clears the status bit
   assign irq = |(st_ff.irq_stat & st_ff.irq_mask);
endmodule // blcl_top

// *** verif/blcl_motor_model.sv ***
// behavioural motor and power stage seen at the fault inputs
`timescale 1ns/10ps
module blcl_motor_model
   import blcl_pkg::*;
(
   input wire logic drive_enable,
   input wire logic [blcl_pkg::VOLT_W-1:0] amplitude_out,
   input wire logic [blcl_pkg::LOCK_SRC_N-1:0] stall,
   input wire logic short_phase,
   input wire logic generating,
   output logic [blcl_pkg::LOCK_SRC_N-1:0] lock_detect,
   output logic overcurrent_protect,
   output logic [blcl_pkg::SPEED_W-1:0] motor_speed,
   output logic [blcl_pkg::VOLT_W-1:0] phase_amplitude,
   output logic [blcl_pkg::VOLT_W-1:0] bemf_amplitude
);
   // a stalled rotor only shows while the windings are driven
   assign lock_detect = drive_enable ? stall : '0;
   assign overcurrent_protect = short_phase;
   assign motor_speed = drive_enable ? 16'h0010 : 16'h0000;
   assign phase_amplitude = amplitude_out;
   // a back-driven motor shows more bemf than is applied
   assign bemf_amplitude = generating ? amplitude_out + 24'h000001 : 24'h000000;
endmodule // blcl_motor_model

// *** verif/blcl_top_chk.sv ***
// checker of fault, surge and retry timing at the top ports
`timescale 1ns/10ps
module blcl_top_chk
   import blcl_pkg::*;
#(
   parameter int LOCK_OFF_CYCLES = 20
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic overcurrent_protect,
   input wire logic [blcl_pkg::LOCK_SRC_N-1:0] lock_detect,
   input wire logic [blcl_pkg::VOLT_W-1:0] amplitude_out,
   input wire logic drive_enable,
   input wire logic anti_surge,
   input wire logic restart_pulse,
   input wire logic hreadyout,
   input wire logic hresp
);
   localparam int LO_N = LOCK_OFF_CYCLES;
   logic [15:0] surge_cnt_ff;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // length of the surge run, too long to unroll as a repetition
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         surge_cnt_ff <= 16'h0000;
      end else begin
         surge_cnt_ff <= anti_surge ? surge_cnt_ff + 16'h0001 : 16'h0000;
      end
   end
   // *****************
   // surge and retry steps
   // *****************
   sequence s_surge_end;
      $fell(anti_surge);
   endsequence
   sequence s_retry;
      restart_pulse && drive_enable && !anti_surge;
   endsequence
   chk_ocp_stops: assert property (overcurrent_protect |=> !drive_enable)
      else $error("drive kept under overcurrent");
   chk_stop_surge: assert property ($fell(drive_enable) && !$past(overcurrent_protect) |-> anti_surge)
      else $error("drive dropped without surge");
   chk_surge_cause: assert property ($rose(anti_surge) |-> $past(|lock_detect))
      else $error("surge without lock");
   chk_surge_hiz: assert property (anti_surge |-> !drive_enable)
      else $error("driving during surge");
   chk_surge_len: assert property (s_surge_end |-> surge_cnt_ff == 16'(SURGE_CYC))
      else $error("surge length wrong");
   chk_lockoff_wait: assert property (s_surge_end |-> ##[LO_N:LO_N] s_retry)
      else $error("retry not after lock-off");
   chk_retry_pulse: assert property (restart_pulse |=> !restart_pulse)
      else $error("retry pulse too long");
   chk_amp_idle: assert property (!drive_enable && !$past(drive_enable) |-> amplitude_out == '0)
      else $error("amplitude while idle");
   chk_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus not ready or error");
endmodule // blcl_top_chk
bind blcl_top blcl_top_chk #(.LOCK_OFF_CYCLES(LOCK_OFF_CYCLES)) blcl_top_chk_inst (.clk(clk),
   .reset(reset), .overcurrent_protect(overcurrent_protect), .lock_detect(lock_detect),
   .amplitude_out(amplitude_out), .drive_enable(drive_enable), .anti_surge(anti_surge),
   .restart_pulse(restart_pulse), .hreadyout(hreadyout), .hresp(hresp));

// *** verif/tb_top.sv ***
// self-checking bench for the current limit, lock and fault block
`timescale 1ns/10ps
module tb_top;
   import blcl_pkg::*;
   localparam int LOCK_OFF = 20;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic closed_loop = 1'b0;
   logic short_phase = 1'b0;
   logic generating = 1'b0;
   logic [5:0] stall = 6'h0;
   logic [23:0] speed_command = 24'h0;
   logic [31:0] hrdata;
   logic [5:0] lock_detect;
   logic [15:0] motor_speed;
   logic [23:0] phase_amplitude, bemf_amplitude, amplitude_out;
   logic [12:0] advance_units;
   logic hreadyout, hresp, overcurrent_protect, drive_enable, anti_surge, restart_pulse, irq;
   int fails = 0;
   int comparisons = 0;
   int n;
   always #25 clk = ~clk;
   blcl_top #(.LOCK_OFF_CYCLES(LOCK_OFF)) blcl_top_inst (.clk(clk), .reset(reset), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .lock_detect(lock_detect), .overcurrent_protect(overcurrent_protect),
      .closed_loop(closed_loop), .motor_speed(motor_speed), .phase_amplitude(phase_amplitude),
      .bemf_amplitude(bemf_amplitude), .speed_command(speed_command),
      .amplitude_out(amplitude_out), .advance_units(advance_units), .drive_enable(drive_enable),
      .anti_surge(anti_surge), .restart_pulse(restart_pulse), .irq(irq));
   blcl_motor_model blcl_motor_model_inst (.drive_enable(drive_enable), .stall(stall),
      .amplitude_out(amplitude_out), .short_phase(short_phase), .generating(generating),
      .lock_detect(lock_detect), .overcurrent_protect(overcurrent_protect),
      .motor_speed(motor_speed), .phase_amplitude(phase_amplitude),
      .bemf_amplitude(bemf_amplitude));
   // *****************
   // shared tasks
   // *****************
   task close_out;
      $display("fails %0d comparisons %0d", fails, comparisons);
      if (fails == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one single transfer; hready is sampled before anything moves on
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      cmp(q, e);
   endtask
   // ends at a falling edge so outputs have settled
   task tick(input int k);
      repeat (k) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic await(ref logic s, input logic v, output int k);
      k = 0;
      while (s !== v && k < 1000) begin
         @(negedge clk);
         k++;
      end
      if (k >= 1000) cmp(32'h0, 32'h1);
   endtask
   function logic [31:0] ctl(input logic [7:0] adv, input logic [3:0] thr, input logic [5:0] en);
      return {14'h0, en, thr, adv};
   endfunction
   // *****************
   // scenarios
   // *****************
   task t_reset;
      rd(ADDR_CTRL, CTRL_RESET);
      rd(ADDR_PARAM, PARAM_RESET);
      rd(8'h1C, 32'h0);
      wr(ADDR_STATUS, 32'hFFFF_FFFF);
      rd(ADDR_STATUS, 32'h40);
   endtask
   task t_adv;
      logic [7:0] c [5] = '{8'h28, 8'h00, 8'h01, 8'h5F, 8'h7F};
      // settings of 80, 0, 2.5, 1200 and 4800 us in 1.25 us units
      logic [12:0] e [5] = '{13'h0040, 13'h0000, 13'h0002, 13'h03C0, 13'h0F00};
      for (int i = 0; i < 5; i++) begin
         wr(ADDR_CTRL, ctl(c[i], 4'h0, 6'h3F));
         tick(3);
         cmp(advance_units, e[i]);
      end
      // mode 1: bemf above the amplitude gives zero, no bemf gives the fixed setting
      @(posedge clk);
      generating <= 1'b1;
      speed_command <= 24'h000100;
      wr(ADDR_CTRL, ctl(8'hA8, 4'h0, 6'h3F));
      tick(3);
      cmp(advance_units, 32'h0);
      @(posedge clk);
      generating <= 1'b0;
      tick(3);
      cmp(advance_units, 32'h40);
   endtask
   // overcurrent twice: once unmasked, once masked
   task t_ocp;
      wr(ADDR_IRQ_STAT, 32'hF);
      for (int m = 1; m >= 0; m--) begin
         wr(ADDR_IRQ_MASK, m ? 32'h2 : 32'h0);
         @(posedge clk);
         short_phase <= 1'b1;
         tick(3);
         cmp(drive_enable, 1'b0);
         cmp(anti_surge, 1'b0);
         cmp(irq, m[0]);
         @(posedge clk);
         short_phase <= 1'b0;
         tick(3);
         cmp(drive_enable, 1'b1);
         rd(ADDR_IRQ_STAT, 32'h2);
         wr(ADDR_IRQ_STAT, 32'h2);
         tick(2);
         cmp(irq, 1'b0);
      end
   endtask
   task t_accel;
      wr(ADDR_PARAM, 32'h0000_0203);
      wr(ADDR_CTRL, ctl(8'h00, 4'h5, 6'h3F));
      @(posedge clk);
      closed_loop <= 1'b1;
      speed_command <= 24'h0003E8;
      tick(4);
      cmp(amplitude_out, 32'h2F);
      rd(ADDR_ULIMIT, 32'h2F);
      cmp(drive_enable, 1'b1);
      @(posedge clk);
      speed_command <= 24'h00000A;
      tick(4);
      cmp(amplitude_out, 32'hA);
      @(posedge clk);
      closed_loop <= 1'b0;
      speed_command <= 24'h0003E8;
      tick(4);
      cmp(amplitude_out, 32'h3E8);
   endtask
   task t_lock;
      wr(ADDR_CTRL, ctl(8'h00, 4'h0, 6'h3E));
      @(posedge clk);
      stall <= 6'h01;
      tick(10);
      cmp(drive_enable, 1'b1);
      rd(ADDR_STATUS, 32'h140);
      @(posedge clk);
      stall <= 6'h00;
      wr(ADDR_CTRL, ctl(8'h00, 4'h0, 6'h3F));
      for (int i = 0; i < 6; i++) begin
         @(posedge clk);
         stall <= 6'h01 << i;
         await(drive_enable, 1'b0, n);
         cmp(anti_surge, 1'b1);
         rd(ADDR_STATUS, 32'hA1 | (32'h100 << i));
         @(posedge clk);
         stall <= 6'h00;
         await(anti_surge, 1'b0, n);
         await(restart_pulse, 1'b1, n);
         cmp(n, LOCK_OFF);
         cmp(drive_enable, 1'b1);
         rd(ADDR_STATUS, 32'h40);
      end
   endtask
   initial begin
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      t_reset;
      t_adv;
      t_ocp;
      t_accel;
      t_lock;
      close_out;
   end
   // watchdog well past the few thousand cycles the scenarios need
   initial begin
      #1000000;
      fails++;
      close_out;
   end
endmodule // tb_top
